// ---- bench/els_responder_tb.sv ----
// Self-checking bench for the link service responder.
// Assumes the remote port model drives the request stream and sinks replies.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) \
  begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module els_responder_tb
  import els_pkg::*;
;
  localparam logic [7:0]  REJ = 8'h01;
  localparam reply_word_t Z   = '0;
  logic        clk = 1'b0;
  logic        resetn;
  logic        rx_valid;
  logic [31:0] rx_data;
  logic        rx_last;
  logic        rx_ready;
  logic        image_pair_established;
  logic        logout_start;
  logic [7:0]  logout_type;
  logic        recipient_missing;
  logic        logout_pending;
  logic        tx_valid;
  reply_word_t tx_word;
  logic        tx_ready;
  int          bad_count = 0;
  int          n_checks  = 0;

  always #25 clk = ~clk;

  els_responder #(.REJECT_CMD(REJ)) i_dut (
    .clk(clk), .resetn(resetn), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
    .rx_ready(rx_ready), .image_pair_established(image_pair_established),
    .logout_start(logout_start), .logout_type(logout_type), .recipient_missing(recipient_missing),
    .logout_pending(logout_pending), .tx_valid(tx_valid), .tx_word(tx_word), .tx_ready(tx_ready)
  );

  remote_port_model i_peer (
    .clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_word(tx_word), .tx_ready(tx_ready)
  );

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  function automatic reply_word_t rw(input logic [31:0] d, input logic l, input logic r);
    return {d, l, r};
  endfunction : rw

  // Waits a little past the expected count so that a surplus word is caught too.
  task automatic expect_reply(input reply_word_t e[$]);
    int k;
    k = 0;
    while (i_peer.got.size() < e.size() && k < 300)
    begin
      @(posedge clk);
      k++;
    end
    repeat (10) @(posedge clk);
    `CHK(i_peer.got.size(), e.size())
    if (k >= 300 || i_peer.hung)
    begin
      bad_count++;
      end_of_test();
    end
    foreach (e[i])
      if (i < i_peer.got.size())
        `CHK(i_peer.got[i], e[i])
    i_peer.got.delete();
  endtask : expect_reply

  task automatic t_accept(input logic est, input int stall);
    @(posedge clk);
    #1;
    image_pair_established = est;
    i_peer.stall = stall;
    i_peer.send_tpls(TPLS_CMD, PAYLOAD_LEN, 4);
    expect_reply('{rw(32'h02100014, 1'b0, 1'b0), rw(32'h00000100, 1'b0, 1'b0), Z, Z,
                   rw({31'h0, est}, 1'b1, 1'b0)});
  endtask : t_accept

  task automatic t_reject(input logic [7:0] cmd, input logic [15:0] len, input int nw);
    i_peer.send_tpls(cmd, len, nw);
    expect_reply('{rw({REJ, 24'h0}, 1'b1, 1'b1)});
  endtask : t_reject

  // The requester side does not repeat a logout after a 0100b answer.
  task automatic t_logout(input logic [7:0] ty, input logic miss);
    @(posedge clk);
    #1;
    logout_type       = ty;
    recipient_missing = miss;
    logout_start      = 1'b1;
    @(posedge clk);
    #1;
    logout_start = 1'b0;
    `CHK(logout_pending, 1'b1)
    @(posedge clk);
    #1;
    `CHK(rx_ready, 1'b0)
    expect_reply('{rw(32'h02100014, 1'b0, 1'b0),
                   rw({ty, 8'h00, 4'h0, miss ? 4'h4 : 4'h1, 8'h00}, 1'b0, 1'b0), Z, Z,
                   rw(32'h0, 1'b1, 1'b0)});
    `CHK(logout_pending, 1'b0)
    `CHK(rx_ready, 1'b1)
  endtask : t_logout

  initial
  begin
    resetn                 = 1'b0;
    image_pair_established = 1'b0;
    logout_start           = 1'b0;
    logout_type            = 8'h00;
    recipient_missing      = 1'b0;
    repeat (5) @(posedge clk);
    `CHK(tx_valid, 1'b0)
    #1;
    resetn = 1'b1;
    t_accept(1'b1, 0);
    t_accept(1'b0, 15);
    t_reject(TPLS_CMD, 16'h0013, 4);
    t_reject(TPLS_CMD, PAYLOAD_LEN, 3);
    t_reject(TPLS_CMD, PAYLOAD_LEN, 0);
    t_reject(TPLS_CMD, PAYLOAD_LEN, 8);
    t_reject(8'h24, PAYLOAD_LEN, 4);
    t_logout(ALL_TYPES, 1'b0);
    t_logout(8'h08, 1'b1);
    end_of_test();
  end

  initial
  begin
    #2000000;
    bad_count++;
    end_of_test();
  end
endmodule : els_responder_tb
`default_nettype wire

// ---- bench/remote_port_model.sv ----
// Behavioural remote port: issues request payloads and sinks the reply stream.
// Assumes the bench calls send_tpls, sets stall, and reads and clears the got queue.
`timescale 1ns/10ps
`default_nettype none
module remote_port_model
  import els_pkg::*;
(
  input  wire logic        clk,
  output var  logic        rx_valid,
  output var  logic [31:0] rx_data,
  output var  logic        rx_last,
  input  wire logic        rx_ready,
  input  wire logic        tx_valid,
  input  wire reply_word_t tx_word,
  output var  logic        tx_ready
);
  reply_word_t got[$];
  int          stall = 0;
  logic        hung  = 1'b0;

  initial
  begin
    rx_valid = 1'b0;
    rx_data  = 32'h0;
    rx_last  = 1'b0;
    tx_ready = 1'b1;
  end

  // A stall longer than the queue depth makes the responder back up into its receive side.
  always @(posedge clk)
  begin
    if (tx_valid && tx_ready)
      got.push_back(tx_word);
    #1;
    tx_ready = (stall == 0);
    stall    = (stall > 0) ? stall - 1 : 0;
  end

  // Source and destination identifiers ride in the frame header, which this payload stream does not carry.
  task automatic send_tpls(input logic [7:0] cmd, input logic [15:0] len, input int nw);
    logic [31:0] w;
    int          k;
    @(posedge clk);
    for (int i = 0; i <= nw; i++)
    begin
      w = (i == 0) ? {cmd, OBS_COMPAT, len} :
          (i == 1) ? 32'h0000c000 : (i == 4) ? 32'h0 : 32'ha5a5a5a5;
      #1;
      rx_valid = 1'b1;
      rx_data  = w;
      rx_last  = (i == nw);
      k = 0;
      do
      begin
        @(posedge clk);
        k++;
      end
      while (!rx_ready && k < 100);
      hung |= (k >= 100);
    end
    #1;
    rx_valid = 1'b0;
    rx_data  = ~w;
    rx_last  = 1'b0;
  endtask : send_tpls
endmodule : remote_port_model
`default_nettype wire

// ---- include/els_pkg.sv ----
// Constants, field layouts and types for the process-login link service responder.
// Assumes payloads move as 32-bit words with byte 0 in bits 31-24.
package els_pkg;

  localparam logic [7:0]  TPLS_CMD      = 8'h23;
  localparam logic [7:0]  ACC_CMD       = 8'h02;
  localparam logic [7:0]  OBS_COMPAT    = 8'h10;
  localparam logic [15:0] PAYLOAD_LEN   = 16'h0014;
  localparam logic [7:0]  ALL_TYPES     = 8'h00;
  localparam logic [3:0]  RSP_EXECUTED  = 4'h1;
  localparam logic [3:0]  RSP_NO_RECIP  = 4'h4;
  localparam logic [2:0]  HDR_IDX       = 3'h0;
  localparam logic [2:0]  PAGE_W0_IDX   = 3'h1;
  localparam logic [2:0]  PAGE_W3_IDX   = 3'h4;
  localparam logic [2:0]  IDX_STEP      = 3'h1;
  localparam int          FIFO_DEPTH    = 4;

  // Word 0 of a request or accept payload.
  typedef struct packed {
    logic [7:0]  cmd;
    logic [7:0]  obsolete;
    logic [15:0] len;
  } hdr_word_t;

  // Word 0 of a response page.
  typedef struct packed {
    logic [7:0] type_code;
    logic [7:0] type_ext;
    logic [3:0] rsvd_hi;
    logic [3:0] rsp_code;
    logic [7:0] rsvd_lo;
  } page_w0_t;

  // Word 3 of a test-login-state response page.
  typedef struct packed {
    logic [30:0] rsvd;
    logic        pair_state;
  } page_w3_t;

  typedef struct packed {
    logic [31:0] data;
    logic        last;
    logic        reject;
  } reply_word_t;

  typedef enum logic [1:0] {
    K_TPLS_ACC,
    K_LOGOUT_ACC,
    K_REJECT
  } reply_kind_t;

endpackage : els_pkg

// ---- logic/els_responder.sv ----
// Responder for the test-login-state request and builder of the logout accept payload.
// Assumes request words arrive on a valid/ready stream with a last marker, and that the
// image pair lookup answers combinationally for the page being received.
`timescale 1ns/10ps
`default_nettype none
// Function
// - A logout page type byte of zero covers all upper-layer types, any other value names one type.
// - The logout accept page carries a four-bit result code in word 0 bits 11-8, 0001b meaning executed.
// - Code 0100b is returned when the exchange recipient does not exist, and the requester must not retry.
// - The type code extension byte of the logout accept page is reserved and carries no meaning.
// - On a test-login-state request the port checks each supplied page against its established pairs; here only one page is accepted.
// - The obsolete byte of word 0 in the request and its accept is always sent as 10h.
// - Every test-login-state request gets exactly one reply, a reject or an accept.
// - The accept starts with 02h in byte 0 and a 16-bit length of 20 in bytes 2-3 of word 0.
// - Each accept response page carries result code 0001b in word 0 bits 11-8.
// - Word 3 bit 0 of the accept page reports the pair state and the other word 3 bits are reserved.
// - The pair state bit is one when the pair is established and zero when not.
module els_responder
  import els_pkg::*;
#(
  parameter logic [7:0] REJECT_CMD = 8'h01
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        rx_valid,
  input  wire logic [31:0] rx_data,
  input  wire logic        rx_last,
  output var  logic        rx_ready,
  input  wire logic        image_pair_established,
  input  wire logic        logout_start,
  input  wire logic [7:0]  logout_type,
  input  wire logic        recipient_missing,
  output var  logic        logout_pending,
  output var  logic        tx_valid,
  output var  reply_word_t tx_word,
  input  wire logic        tx_ready
);

  typedef enum logic [1:0] {S_IDLE, S_RX, S_DRAIN, S_TX} state_t;

  state_t      state, next_state;
  reply_kind_t kind, next_kind;
  logic [2:0]  cnt, next_cnt;
  logic [2:0]  idx, next_idx;
  logic        bad, next_bad;
  logic        est, next_est;
  logic [7:0]  type_q, next_type_q;
  logic [3:0]  code_q, next_code_q;
  logic        next_rx_ready;
  logic        next_logout_pending;
  logic        rx_fire;
  logic        push;
  logic        fifo_ready;
  reply_word_t push_word;
  hdr_word_t   rx_hdr;

  function automatic logic [31:0] build_word(reply_kind_t k, logic [2:0] i, logic [7:0] t,
                                             logic [3:0] c, logic st, logic [7:0] rj);
    hdr_word_t h;
    page_w0_t  p0;
    page_w3_t  p3;
    h  = '0;
    p0 = '0;
    p3 = '0;
    if (k == K_REJECT)
    begin
      h.cmd = rj;
      return h;
    end
    if (i == HDR_IDX)
    begin
      h.cmd      = ACC_CMD;
      h.obsolete = OBS_COMPAT;
      h.len      = PAYLOAD_LEN;
      return h;
    end
    if (i == PAGE_W0_IDX)
    begin
      if (k == K_LOGOUT_ACC)
      begin
        p0.type_code = t;
        p0.type_ext  = '0;
        p0.rsp_code  = c;
      end
      else
      begin
        p0.rsp_code  = RSP_EXECUTED;
      end
      return p0;
    end
    if (i == PAGE_W3_IDX && k == K_TPLS_ACC)
    begin
      p3.pair_state = st;
      return p3;
    end
    // Obsolete and reserved words go out as zero.
    return '0;
  endfunction : build_word

  assign rx_hdr  = rx_data;
  assign rx_fire = rx_valid && rx_ready;
  assign push    = (state == S_TX) && fifo_ready;

  always_comb
  begin
    push_word.data   = build_word(kind, idx, type_q, code_q, est, REJECT_CMD);
    push_word.reject = (kind == K_REJECT);
    push_word.last   = (kind == K_REJECT) || (idx == PAGE_W3_IDX);
  end

  always_comb
  begin
    next_state          = state;
    next_kind           = kind;
    next_cnt            = cnt;
    next_idx            = idx;
    next_bad            = bad;
    next_est            = est;
    next_type_q         = type_q;
    next_code_q         = code_q;
    next_logout_pending = logout_pending || logout_start;
    case (state)
      S_IDLE:
      begin
        if (rx_fire)
        begin
          // The obsolete byte is not checked on reception.
          next_bad = (rx_hdr.cmd != TPLS_CMD) || (rx_hdr.len != PAYLOAD_LEN);
          next_cnt = HDR_IDX + IDX_STEP;
          if (rx_last)
          begin
            next_kind  = K_REJECT;
            next_idx   = HDR_IDX;
            next_state = S_TX;
          end
          else
          begin
            next_state = S_RX;
          end
        end
        else if (logout_pending)
        begin
          next_kind           = K_LOGOUT_ACC;
          next_type_q         = logout_type;
          next_code_q         = recipient_missing ? RSP_NO_RECIP : RSP_EXECUTED;
          next_idx            = HDR_IDX;
          next_logout_pending = logout_start;
          next_state          = S_TX;
        end
      end
      S_RX:
      begin
        if (rx_fire)
        begin
          next_cnt = cnt + IDX_STEP;
          if (cnt == PAGE_W3_IDX)
          begin
            next_est = image_pair_established;
          end
          if (rx_last)
          begin
            next_kind  = (bad || cnt != PAGE_W3_IDX) ? K_REJECT : K_TPLS_ACC;
            next_idx   = HDR_IDX;
            next_state = S_TX;
          end
          else if (cnt == PAGE_W3_IDX)
          begin
            // Words beyond the one page allowed by the length make the payload malformed.
            next_bad   = 1'b1;
            next_state = S_DRAIN;
          end
        end
      end
      S_DRAIN:
      begin
        if (rx_fire && rx_last)
        begin
          next_kind  = K_REJECT;
          next_idx   = HDR_IDX;
          next_state = S_TX;
        end
      end
      S_TX:
      begin
        if (push)
        begin
          if (push_word.last)
          begin
            next_state = S_IDLE;
          end
          else
          begin
            next_idx = idx + IDX_STEP;
          end
        end
      end
      default:
      begin
        next_state = S_IDLE;
      end
    endcase
    // New requests are held off while a reply is being queued, so each gets one answer.
    next_rx_ready = (next_state != S_TX);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state          <= S_IDLE;
      kind           <= K_REJECT;
      cnt            <= HDR_IDX;
      idx            <= HDR_IDX;
      bad            <= 1'b0;
      est            <= 1'b0;
      type_q         <= ALL_TYPES;
      code_q         <= RSP_EXECUTED;
      rx_ready       <= 1'b0;
      logout_pending <= 1'b0;
    end
    else
    begin
      state          <= next_state;
      kind           <= next_kind;
      cnt            <= next_cnt;
      idx            <= next_idx;
      bad            <= next_bad;
      est            <= next_est;
      type_q         <= next_type_q;
      code_q         <= next_code_q;
      rx_ready       <= next_rx_ready;
      logout_pending <= next_logout_pending;
    end
  end

  word_fifo #(
    .WIDTH ($bits(reply_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_reply_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (state == S_TX),
    .in_data   (push_word),
    .in_ready  (fifo_ready),
    .out_valid (tx_valid),
    .out_data  (tx_word),
    .out_ready (tx_ready)
  );

  // Marks the first word of each outgoing reply.
  logic tx_first;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_first <= 1'b1;
    end
    else if (tx_valid && tx_ready)
    begin
      tx_first <= tx_word.last;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_accept_header: assert property (tx_valid && tx_first && !tx_word.reject |->
    tx_word.data == {ACC_CMD, OBS_COMPAT, PAYLOAD_LEN}) else $error("accept header wrong");
  a_reject_single: assert property (tx_valid && tx_word.reject |-> tx_word.last)
    else $error("reject reply longer than one word");
  a_tpls_code: assert property (push && kind == K_TPLS_ACC && idx == PAGE_W0_IDX |->
    push_word.data == {16'h0000, 4'h0, RSP_EXECUTED, 8'h00}) else $error("test page result code wrong");
  a_pair_state: assert property (push && kind == K_TPLS_ACC && idx == PAGE_W3_IDX |->
    push_word.data == {31'h0, est}) else $error("pair state word wrong");
  a_sample_est: assert property (rx_fire && state == S_RX && cnt == PAGE_W3_IDX |=>
    est == $past(image_pair_established)) else $error("pair state not sampled");
  a_logout_code: assert property (state == S_IDLE && !rx_fire && logout_pending |=>
    code_q == ($past(recipient_missing) ? RSP_NO_RECIP : RSP_EXECUTED)) else $error("logout code wrong");
  a_logout_type: assert property (push && kind == K_LOGOUT_ACC && idx == PAGE_W0_IDX |->
    push_word.data[31:24] == type_q && push_word.data[23:16] == 8'h00) else $error("logout type bytes wrong");
  a_bad_length: assert property (rx_fire && state == S_IDLE && rx_hdr.len != PAYLOAD_LEN |=>
    bad || kind == K_REJECT) else $error("bad length not flagged");
  a_one_reply: assert property (rx_fire && rx_last && state != S_TX |=>
    state == S_TX && !rx_ready) else $error("request end without reply");

  c_accept_sent: cover property (tx_valid && tx_ready && tx_first && !tx_word.reject);
  c_reject_sent: cover property (tx_valid && tx_ready && tx_word.reject);
  c_logout_sent: cover property (push && kind == K_LOGOUT_ACC && push_word.last);
  c_fifo_full:   cover property (state == S_TX && !fifo_ready);

endmodule : els_responder
`default_nettype wire

// ---- logic/word_fifo.sv ----
// Shift-register FIFO with valid/ready on both sides and registered outputs.
// Assumes the drain side may hold out_ready low for any time.
`timescale 1ns/10ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             in_ready,
  output var  logic             out_valid,
  output var  logic [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);

  logic [WIDTH-1:0] mem      [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [DEPTH-1:0] vld;
  logic [DEPTH-1:0] next_vld;
  logic             next_in_ready;

  // The head always sits in entry 0, so the outputs come straight from flops.
  always_comb
  begin
    logic placed;
    placed   = 1'b0;
    next_mem = mem;
    next_vld = vld;
    if (vld[0] && out_ready)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
      begin
        next_mem[i] = mem[i+1];
        next_vld[i] = vld[i+1];
      end
      next_vld[DEPTH-1] = 1'b0;
    end
    if (in_valid && in_ready)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        if (!placed && !next_vld[i])
        begin
          next_mem[i] = in_data;
          next_vld[i] = 1'b1;
          placed      = 1'b1;
        end
      end
    end
    next_in_ready = !next_vld[DEPTH-1];
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem[i] <= '0;
      end
      vld      <= '0;
      in_ready <= 1'b0;
    end
    else
    begin
      mem      <= next_mem;
      vld      <= next_vld;
      in_ready <= next_in_ready;
    end
  end

  assign out_valid = vld[0];
  assign out_data  = mem[0];

endmodule : word_fifo
`default_nettype wire
